// >>> design/gtt_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "gtt_defs.vh"
module gtt_ctrl #(
    parameter TICK_CYC = `GTT_TICK_CYC
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        tmo_set,
    input  wire [23:0] timeout_seconds_value,
    input  wire        xfer_start,
    input  wire        xfer_cont_dma,
    input  wire        xfer_byte,
    input  wire        xfer_done,
    input  wire        tmo_err_clr,
    output reg         xfer_abort_reg,
    output reg         tmo_err_reg,
    output reg         xfer_active_reg,
    input  wire        is_active_ctrl,
    input  wire        trig_start,
    input  wire        trig_addr_valid,
    input  wire [4:0]  trig_pad,
    input  wire        trig_has_sad,
    input  wire [4:0]  trig_sad,
    input  wire        trig_addr_last,
    output reg         trig_addr_ready_reg,
    input  wire        bus_cmd_ready,
    output reg         bus_cmd_valid_reg,
    output reg  [7:0]  bus_cmd_data_reg,
    output reg         trig_busy_reg,
    output reg         trig_done_reg,
    output reg         trig_refused_reg
);
    wire tick;
    gtt_tick_div #(.TICK_CYC(TICK_CYC)) u_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .tick_reg (tick)
    );

    // Nearest multiple of 5.5 cs: ticks = round(2*cs/11), floor of 2 ticks unless cs is zero.
    function [23:0] cs_to_ticks;
        input [23:0] cs;
        reg   [25:0] q;
        begin
            q = ({2'b00, cs} * 26'd2 + 26'd5) / 26'd11;
            if (cs == 24'h000000)
                cs_to_ticks = 24'h000000;
            else if (cs <= `GTT_CS_PER_TICK2 || q[23:0] < `GTT_MIN_TICKS)
                cs_to_ticks = `GTT_MIN_TICKS;
            else
                cs_to_ticks = q[23:0];
        end
    endfunction

    reg [23:0] limit_reg;
    reg [23:0] tcnt_reg;
    reg        timing_reg;
    reg        tmo_hit;

    always @(posedge clk) begin
        if (!reset_n)
            limit_reg <= `GTT_DEFAULT_TICKS;
        else if (tmo_set)
            limit_reg <= cs_to_ticks(timeout_seconds_value);
    end

    always @* begin
        // Zero limit never expires.
        tmo_hit = xfer_active_reg && timing_reg && (limit_reg != 24'h000000)
                  && tick && (tcnt_reg + 24'h000001 >= limit_reg);
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            xfer_active_reg <= 1'b0;
            timing_reg      <= 1'b0;
            tcnt_reg        <= 24'h000000;
            xfer_abort_reg  <= 1'b0;
            tmo_err_reg     <= 1'b0;
        end else begin
            xfer_abort_reg <= 1'b0;
            if (tmo_hit)
                tmo_err_reg <= 1'b1;
            else if (tmo_err_clr)
                tmo_err_reg <= 1'b0;
            if (tmo_hit) begin
                xfer_abort_reg  <= 1'b1;
                xfer_active_reg <= 1'b0;
                timing_reg      <= 1'b0;
            end else if (xfer_start) begin
                xfer_active_reg <= 1'b1;
                timing_reg      <= 1'b1;
                tcnt_reg        <= 24'h000000;
            end else if (xfer_active_reg) begin
                if (xfer_done) begin
                    xfer_active_reg <= 1'b0;
                    timing_reg      <= 1'b0;
                end else if (xfer_byte) begin
                    tcnt_reg <= 24'h000000;
                    if (xfer_cont_dma)
                        timing_reg <= 1'b0;
                end else if (tick) begin
                    tcnt_reg <= tcnt_reg + 24'h000001;
                end
            end
        end
    end

    reg [2:0] st_reg;
    reg [4:0] sad_reg;
    reg       last_reg;
    reg       sec_reg;

    // Hands one command byte to the bus and moves on once it is taken.
    always @(posedge clk) begin
        if (!reset_n) begin
            st_reg              <= `GTT_S_IDLE;
            sad_reg             <= 5'h00;
            last_reg            <= 1'b0;
            sec_reg             <= 1'b0;
            trig_addr_ready_reg <= 1'b0;
            bus_cmd_valid_reg   <= 1'b0;
            bus_cmd_data_reg    <= 8'h00;
            trig_busy_reg       <= 1'b0;
            trig_done_reg       <= 1'b0;
            trig_refused_reg    <= 1'b0;
        end else begin
            trig_done_reg       <= 1'b0;
            trig_refused_reg    <= 1'b0;
            trig_addr_ready_reg <= 1'b0;
            case (st_reg)
                `GTT_S_IDLE: begin
                    if (trig_start) begin
                        if (!is_active_ctrl) begin
                            trig_refused_reg <= 1'b1;
                        end else begin
                            trig_busy_reg <= 1'b1;
                            if (trig_addr_valid) begin
                                bus_cmd_data_reg  <= `GTT_CMD_UNL;
                                bus_cmd_valid_reg <= 1'b1;
                                st_reg            <= `GTT_S_UNL;
                            end else begin
                                bus_cmd_data_reg  <= `GTT_CMD_GET;
                                bus_cmd_valid_reg <= 1'b1;
                                st_reg            <= `GTT_S_GET;
                            end
                        end
                    end
                end
                `GTT_S_UNL, `GTT_S_SEC: begin
                    if (bus_cmd_ready) begin
                        bus_cmd_valid_reg <= 1'b0;
                        st_reg            <= (st_reg == `GTT_S_SEC || !sec_reg) && last_reg
                                             ? `GTT_S_WAIT : `GTT_S_ADDR;
                        if (st_reg == `GTT_S_UNL)
                            st_reg <= `GTT_S_ADDR;
                    end
                end
                `GTT_S_ADDR: begin
                    if (bus_cmd_valid_reg) begin
                        if (bus_cmd_ready) begin
                            bus_cmd_valid_reg <= 1'b0;
                            st_reg <= sec_reg ? `GTT_S_SEC : (last_reg ? `GTT_S_WAIT : `GTT_S_ADDR);
                            if (sec_reg) begin
                                bus_cmd_data_reg  <= `GTT_CMD_SAG | {3'h0, sad_reg};
                                bus_cmd_valid_reg <= 1'b1;
                            end
                        end
                    end else if (trig_addr_valid && trig_pad <= `GTT_PAD_MAX) begin
                        trig_addr_ready_reg <= 1'b1;
                        bus_cmd_data_reg    <= `GTT_CMD_LAG | {3'h0, trig_pad};
                        bus_cmd_valid_reg   <= 1'b1;
                        sad_reg             <= trig_sad;
                        sec_reg             <= trig_has_sad;
                        last_reg            <= trig_addr_last;
                    end
                end
                `GTT_S_WAIT: begin
                    bus_cmd_data_reg  <= `GTT_CMD_GET;
                    bus_cmd_valid_reg <= 1'b1;
                    st_reg            <= `GTT_S_GET;
                end
                `GTT_S_GET: begin
                    if (bus_cmd_ready) begin
                        bus_cmd_valid_reg <= 1'b0;
                        trig_busy_reg     <= 1'b0;
                        trig_done_reg     <= 1'b1;
                        st_reg            <= `GTT_S_IDLE;
                    end
                end
                default: st_reg <= `GTT_S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> design/gtt_defs.vh
`ifndef GTT_DEFS_VH
`define GTT_DEFS_VH
// Coarse tick period in microseconds and system clock period in nanoseconds.
`define GTT_TICK_US        55000
`define GTT_CLK_NS         10
`define GTT_TICK_CYC       ((`GTT_TICK_US * 1000) / `GTT_CLK_NS)
`define GTT_TICK_W         23
// Timeout is given in hundredths of a second; 24 bits cover 167772.15 s.
`define GTT_CS_W           24
`define GTT_TICKS_W        24
`define GTT_CS_PER_TICK2   24'd11
`define GTT_MIN_TICKS      24'h000002
`define GTT_DEFAULT_TICKS  24'h0000b6
// Bus command bytes.
`define GTT_CMD_UNL        8'h3f
`define GTT_CMD_LAG        8'h20
`define GTT_CMD_SAG        8'h60
`define GTT_CMD_GET        8'h08
`define GTT_PAD_MAX        5'h1e
// Trigger sequencer states.
`define GTT_S_IDLE         3'h0
`define GTT_S_UNL          3'h1
`define GTT_S_ADDR         3'h2
`define GTT_S_SEC          3'h3
`define GTT_S_GET          3'h4
`define GTT_S_WAIT         3'h5
`endif

// >>> design/gtt_tick_div.v
`timescale 1ns/1ns
`default_nettype none
`include "gtt_defs.vh"
module gtt_tick_div #(
    parameter TICK_CYC = `GTT_TICK_CYC
) (
    input  wire clk,
    input  wire reset_n,
    output reg  tick_reg
);
    reg [`GTT_TICK_W-1:0] cnt_reg;
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_reg  <= {`GTT_TICK_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (cnt_reg == TICK_CYC[`GTT_TICK_W-1:0] - 1'b1) begin
            cnt_reg  <= {`GTT_TICK_W{1'b0}};
            tick_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/gtt_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// Instrument side of the command handshake: accepts promptly, then slowly, in turn.
module gtt_bus_model (
    input  wire logic       clk,
    input  wire logic       valid,
    input  wire logic [7:0] data,
    output var  logic       ready
);
    logic [7:0] got[$];
    int         w   = 0;
    int         dly = 0;
    initial ready = 1'b0;
    always @(posedge clk) begin
        ready <= 1'b0;
        if (valid && ready) begin
            got.push_back(data);
        end else if (valid) begin
            if (w >= dly) begin
                ready <= 1'b1;
                w     <= 0;
                dly   <= 2 - dly;
            end else begin
                w <= w + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/gtt_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module gtt_chk (
    input wire       clk,
    input wire       reset_n,
    input wire       tmo_err_clr,
    input wire       xfer_abort_reg,
    input wire       tmo_err_reg,
    input wire       xfer_active_reg,
    input wire       is_active_ctrl,
    input wire       trig_start,
    input wire       trig_addr_valid,
    input wire [4:0] trig_pad,
    input wire       trig_addr_ready_reg,
    input wire       bus_cmd_ready,
    input wire       bus_cmd_valid_reg,
    input wire [7:0] bus_cmd_data_reg,
    input wire       trig_busy_reg,
    input wire       trig_done_reg,
    input wire       trig_refused_reg
);
    reg  [7:0] last_reg;
    wire       go = trig_start && !trig_busy_reg;
    always @(posedge clk) if (bus_cmd_valid_reg && bus_cmd_ready) last_reg <= bus_cmd_data_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_err_sticky: assert property ($fell(tmo_err_reg) |-> $past(tmo_err_clr))
        else $error("timeout flag fell without a clear");
    chk_abort_flags: assert property (xfer_abort_reg |-> tmo_err_reg)
        else $error("abort without timeout flag");
    chk_abort_idle: assert property (xfer_abort_reg |=> !xfer_abort_reg && !xfer_active_reg)
        else $error("abort did not end the transfer");
    chk_trig_refused: assert property (go && !is_active_ctrl |=> trig_refused_reg && !trig_busy_reg)
        else $error("trigger not refused");
    chk_cmd_hold: assert property (bus_cmd_valid_reg && !bus_cmd_ready |=> bus_cmd_valid_reg && $stable(bus_cmd_data_reg))
        else $error("command byte dropped before ready");
    chk_done_get: assert property (trig_done_reg |-> last_reg == 8'h08)
        else $error("trigger done without trigger byte");
    chk_pad_range: assert property (trig_addr_ready_reg |-> trig_pad <= 5'h1e)
        else $error("primary address above range taken");
    chk_unl_first: assert property (go && is_active_ctrl && trig_addr_valid |-> ##[1:4] bus_cmd_valid_reg && bus_cmd_data_reg == 8'h3f)
        else $error("unlisten not sent first");
    chk_get_direct: assert property (go && is_active_ctrl && !trig_addr_valid |-> ##[1:4] bus_cmd_valid_reg && bus_cmd_data_reg == 8'h08)
        else $error("trigger byte not sent directly");
    cover property (xfer_abort_reg);
    cover property (trig_refused_reg);
    cover property (trig_done_reg);
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int TC = 50;
    logic clk = 0, reset_n = 0, tset = 0, xs = 0, dma = 0, xb = 0, xd = 0, clr = 0;
    logic ac = 0, ts = 0, av = 0, hs = 0, al = 0;
    logic [23:0] tsv = 24'h0;
    logic [4:0]  pad = 5'h0, sad = 5'h0;
    wire         abrt, err, act, ardy, rdy, cv, busy, done, refd;
    wire [7:0]   cd;
    int          miscompares = 0, n_checks = 0, cyc = 0, n;
    logic [23:0] cs_t[6] = '{24'h0, 24'h1, 24'hb, 24'h10, 24'h32, 24'h1f4};
    int          tk_t[6] = '{0, 2, 2, 3, 9, 91};
    logic [7:0]  ex[5] = '{8'h3f, 8'h24, 8'h3e, 8'h7f, 8'h08};
    initial forever #5 clk = ~clk;
    gtt_ctrl #(.TICK_CYC(TC)) dut (.clk(clk), .reset_n(reset_n), .tmo_set(tset),
        .timeout_seconds_value(tsv), .xfer_start(xs), .xfer_cont_dma(dma), .xfer_byte(xb),
        .xfer_done(xd), .tmo_err_clr(clr), .xfer_abort_reg(abrt), .tmo_err_reg(err),
        .xfer_active_reg(act), .is_active_ctrl(ac), .trig_start(ts), .trig_addr_valid(av),
        .trig_pad(pad), .trig_has_sad(hs), .trig_sad(sad), .trig_addr_last(al),
        .trig_addr_ready_reg(ardy), .bus_cmd_ready(rdy), .bus_cmd_valid_reg(cv),
        .bus_cmd_data_reg(cd), .trig_busy_reg(busy), .trig_done_reg(done),
        .trig_refused_reg(refd));
    gtt_bus_model bm (.clk(clk), .valid(cv), .data(cd), .ready(rdy));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Strobes are raised and dropped at edges; only one is ever raised at a time.
    task automatic pulse(input int k);
        @(posedge clk) case (k)
            0: tset <= 1;
            1: xs <= 1;
            2: xb <= 1;
            3: clr <= 1;
            default: xd <= 1;
        endcase
        @(posedge clk) {tset, xs, xb, clr, xd} <= 5'h0;
    endtask
    task automatic wait_on(input int lim, input int sel);
        n = 0;
        #1;
        while ((sel == 0 ? abrt : sel == 1 ? done : ardy) !== 1'b1 && n < lim) begin
            @(posedge clk) ts <= 0;
            #1;
            n++;
        end
    endtask
    // The tick runs free, so an expiry may land one tick either side.
    task automatic expect_tmo(input int t);
        wait_on((t + 8) * TC, 0);
        check(n >= (t - 1) * TC && n <= (t + 1) * TC + 3, 1);
        check({err, act}, 2'h2);
        pulse(3);
        #1;
        check(err, 0);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1;
        #1;
        check({abrt, err, act, ardy, cv, busy, done, refd}, 8'h0);
        pulse(1);
        expect_tmo(182);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) tsv <= cs_t[i];
            pulse(0);
            pulse(1);
            if (tk_t[i] == 0) begin
                wait_on(8 * TC, 0);
                check(err, 0);
                pulse(4);
            end else begin
                expect_tmo(tk_t[i]);
            end
        end
        // Nine ticks, so six-tick gaps pass only if each byte restarts the count.
        @(posedge clk) tsv <= 24'h32;
        pulse(0);
        pulse(1);
        repeat (3) begin
            repeat (300) @(posedge clk);
            pulse(2);
        end
        check(err, 0);
        expect_tmo(9);
        @(posedge clk) dma <= 1;
        pulse(1);
        expect_tmo(9);
        pulse(1);
        pulse(2);
        repeat (1000) @(posedge clk);
        check(err, 0);
        check(act, 1);
        pulse(4);
        @(posedge clk) ts <= 1;
        @(posedge clk) ts <= 0;
        #1;
        check(refd, 1);
        @(posedge clk) begin
            ac <= 1;
            ts <= 1;
        end
        wait_on(100, 1);
        check(bm.got.size(), 1);
        check(bm.got[0], 8'h08);
        bm.got.delete();
        for (int e = 0; e < 2; e++) begin
            @(posedge clk) begin
                ts  <= (e == 0);
                av  <= 1;
                pad <= e ? 5'h1e : 5'h04;
                hs  <= (e == 1);
                sad <= 5'h1f;
                al  <= (e == 1);
            end
            wait_on(100, 2);
        end
        @(posedge clk) {av, al} <= 2'h0;
        wait_on(100, 1);
        check(bm.got.size(), 5);
        foreach (ex[k]) check(bm.got[k], ex[k]);
        print_verdict;
    end
endmodule
bind gtt_ctrl gtt_chk chk (.clk(clk), .reset_n(reset_n), .tmo_err_clr(tmo_err_clr),
    .xfer_abort_reg(xfer_abort_reg), .tmo_err_reg(tmo_err_reg),
    .xfer_active_reg(xfer_active_reg), .is_active_ctrl(is_active_ctrl),
    .trig_start(trig_start), .trig_addr_valid(trig_addr_valid), .trig_pad(trig_pad),
    .trig_addr_ready_reg(trig_addr_ready_reg), .bus_cmd_ready(bus_cmd_ready),
    .bus_cmd_valid_reg(bus_cmd_valid_reg), .bus_cmd_data_reg(bus_cmd_data_reg),
    .trig_busy_reg(trig_busy_reg), .trig_done_reg(trig_done_reg),
    .trig_refused_reg(trig_refused_reg));
`default_nettype wire
